// ### core/amct_map.svh
`ifndef AMCT_MAP_SVH
`define AMCT_MAP_SVH

`define AMCT_ADDR_CHAN 8'h05
`define AMCT_ADDR_PWR 8'h08
`define AMCT_ADDR_GCLK 8'h09
`define AMCT_ADDR_DIV 8'h0B
`define AMCT_ADDR_TEST 8'h0D
`define AMCT_ADDR_UPAT_LO 8'h19
`define AMCT_ADDR_UPAT_HI 8'h1A

`define AMCT_RST_CHAN 2'h3
`define AMCT_RST_PWR 8'h00
`define AMCT_RST_GCLK 8'h01
`define AMCT_RST_DIV 8'h00
`define AMCT_RST_TEST 8'h00
`define AMCT_RST_UPAT 12'h000

`define AMCT_PWR_PDFN_BIT 5
`define AMCT_GCLK_CORR_BIT 0
`define AMCT_DIV_PHASE_LSB 3
`define AMCT_TEST_SINGLE_BIT 7
`define AMCT_TEST_RST_LONG_BIT 5
`define AMCT_TEST_RST_SHORT_BIT 4

`define AMCT_PRBS_LONG_SEED 23'h7FFFFF
`define AMCT_PRBS_SHORT_SEED 9'h1FF
`define AMCT_CALM_CYCLES 5'h10

`endif

// ### core/amct_pkg.sv
package amct_pkg;
  typedef enum logic [3:0] {
    amct_tm_off = 4'h0,
    amct_tm_midscale = 4'h1,
    amct_tm_pos_full_scale = 4'h2,
    amct_tm_neg_full_scale = 4'h3,
    amct_tm_checker = 4'h4,
    amct_tm_prbs_long = 4'h5,
    amct_tm_prbs_short = 4'h6,
    amct_tm_toggle = 4'h7,
    amct_tm_user = 4'h8,
    amct_tm_ramp = 4'hF
  } amct_test_e;

  typedef enum logic [1:0] {
    amct_pwr_normal = 2'h0,
    amct_pwr_full_down = 2'h1,
    amct_pwr_standby = 2'h2,
    amct_pwr_reserved = 2'h3
  } amct_pwr_e;
endpackage

// ### core/amct_pat_if.sv
`timescale 1ns/1ps
interface amct_pat_if #(parameter int W = 12);
  logic tick;
  logic restart;
  logic [3:0] mode;
  logic single;
  logic rst_long;
  logic rst_short;
  logic [W-1:0] user_pat;
  logic [W-1:0] sample;
  logic [W-1:0] out_data;
  modport regs (output tick, restart, mode, single, rst_long, rst_short,
    user_pat, sample, input out_data);
  modport gen (input tick, restart, mode, single, rst_long, rst_short,
    user_pat, sample, output out_data);
endinterface

// ### core/amct_pattern_gen.sv
`timescale 1ns/1ps
`include "amct_map.svh"
module amct_pattern_gen import amct_pkg::*; #(
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Configuration, sample strobe and output word.
  amct_pat_if.gen pif
);
  logic [22:0] long_prbs;
  logic [8:0] short_prbs;
  logic tog;
  logic sent;
  logic [W-1:0] ramp;
  logic [W-1:0] out_q;

  assign pif.out_data = out_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      long_prbs <= `AMCT_PRBS_LONG_SEED;
    end else if (pif.rst_long) begin
      long_prbs <= `AMCT_PRBS_LONG_SEED;
    end else if (pif.tick && pif.mode == amct_tm_prbs_long) begin
      long_prbs <= {long_prbs[21:0], long_prbs[22] ^ long_prbs[17]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      short_prbs <= `AMCT_PRBS_SHORT_SEED;
    end else if (pif.rst_short) begin
      short_prbs <= `AMCT_PRBS_SHORT_SEED;
    end else if (pif.tick && pif.mode == amct_tm_prbs_short) begin
      short_prbs <= {short_prbs[7:0], short_prbs[8] ^ short_prbs[4]};
    end
  end

  // A new test code restarts the toggle, the ramp and the single shot.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog <= 1'b0;
      sent <= 1'b0;
      ramp <= '0;
    end else if (pif.restart) begin
      tog <= 1'b0;
      sent <= 1'b0;
      ramp <= '0;
    end else if (pif.tick) begin
      tog <= ~tog;
      ramp <= ramp + 1'b1;
      if (pif.mode == amct_tm_user) begin
        sent <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
    end else if (pif.tick) begin
      case (pif.mode)
        amct_tm_off: out_q <= pif.sample;
        amct_tm_midscale: out_q <= {1'b1, {(W-1){1'b0}}};
        amct_tm_pos_full_scale: out_q <= '1;
        amct_tm_neg_full_scale: out_q <= '0;
        amct_tm_checker: begin
          out_q <= tog ? {(W/2){2'b01}} : {(W/2){2'b10}};
        end
        amct_tm_prbs_long: out_q <= long_prbs[W-1:0];
        amct_tm_prbs_short: out_q <= {{(W-9){1'b0}}, short_prbs};
        amct_tm_toggle: out_q <= tog ? '0 : '1;
        amct_tm_user: begin
          out_q <= (pif.single && sent) ? '0 : pif.user_pat;
        end
        amct_tm_ramp: out_q <= ramp;
        default: out_q <= '0;
      endcase
    end
  end

  sequence s_tick_in(logic [3:0] m);
    pif.tick && !pif.restart && pif.mode == m;
  endsequence

  property p_pass_through;
    @(posedge clk) disable iff (!rstn)
    s_tick_in(amct_tm_off) |=> out_q == $past(pif.sample);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("Converted sample not passed with test mode off.");

  property p_pos_full_scale;
    @(posedge clk) disable iff (!rstn)
    s_tick_in(amct_tm_pos_full_scale) |=> out_q == {W{1'b1}};
  endproperty
  a_pos_full_scale: assert property (p_pos_full_scale)
    else $error("Positive full scale code wrong.");

  property p_long_seed;
    @(posedge clk) disable iff (!rstn)
    pif.rst_long |=> long_prbs == `AMCT_PRBS_LONG_SEED;
  endproperty
  a_long_seed: assert property (p_long_seed)
    else $error("Long sequence generator not reset.");

  property p_toggle;
    @(posedge clk) disable iff (!rstn)
    s_tick_in(amct_tm_toggle) ##1 s_tick_in(amct_tm_toggle)
      |=> (out_q == ~$past(out_q)) && (out_q == '0 || out_q == '1);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("Word toggle did not alternate ones and zeros.");

  property p_single_then_zero;
    @(posedge clk) disable iff (!rstn)
    s_tick_in(amct_tm_user) ##0 (pif.single && sent) |=> out_q == '0;
  endproperty
  a_single_then_zero: assert property (p_single_then_zero)
    else $error("Single user pattern not followed by zeros.");
endmodule

// ### core/amct_regs.sv
`timescale 1ns/1ps
`include "amct_map.svh"
module amct_regs import amct_pkg::*; #(
  parameter int NCH = 2,
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // External power-down pin.
  input wire logic pdwn_pin,
  // Converted samples in, channel data out.
  input wire logic [NCH-1:0][W-1:0] sample,
  output logic [NCH-1:0][W-1:0] out_data,
  output logic out_valid,
  // Clock path and power state.
  output logic div_tick,
  output logic duty_cycle_corrector_on,
  output logic [NCH-1:0][1:0] power_state
);
  logic [1:0] pd_sync;
  logic [NCH-1:0] chan_sel;
  logic [NCH-1:0][1:0] pwr_mode;
  logic [NCH-1:0] pd_fn;
  logic [NCH-1:0][3:0] test_mode;
  logic [NCH-1:0] single;
  logic [NCH-1:0] rst_long;
  logic [NCH-1:0] rst_short;
  logic [NCH-1:0][W-1:0] user_pat;
  logic corrector_en;
  logic [2:0] div_ratio;
  logic [2:0] div_phase;
  logic [2:0] div_cnt;
  logic [6:0] div_dly;
  logic [7:0] tick_vec;
  logic rd_ch;
  logic [7:0] next_rdata;

  // The pin arrives from outside the clock domain.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_sync <= 2'h0;
    end else begin
      pd_sync <= {pd_sync[0], pdwn_pin};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_sel <= `AMCT_RST_CHAN;
    end else if (wr && addr == `AMCT_ADDR_CHAN) begin
      chan_sel <= wdata[NCH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      corrector_en <= 1'(`AMCT_RST_GCLK >> `AMCT_GCLK_CORR_BIT);
      div_ratio <= 3'(`AMCT_RST_DIV);
      div_phase <= 3'(`AMCT_RST_DIV >> `AMCT_DIV_PHASE_LSB);
    end else if (wr && addr == `AMCT_ADDR_GCLK) begin
      corrector_en <= wdata[`AMCT_GCLK_CORR_BIT];
    end else if (wr && addr == `AMCT_ADDR_DIV) begin
      div_ratio <= wdata[2:0];
      div_phase <= wdata[`AMCT_DIV_PHASE_LSB +: 3];
    end
  end

  assign duty_cycle_corrector_on = corrector_en || (div_ratio != 3'h0);

  // Code 111 divides by eight, the natural end of the counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 3'h0;
    end else if (div_cnt >= div_ratio) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_dly <= 7'h00;
    end else begin
      div_dly <= tick_vec[6:0];
    end
  end

  assign tick_vec = {div_dly, div_cnt == 3'h0};
  assign div_tick = tick_vec[div_phase];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= div_tick;
    end
  end

  // Reserved power code 11 leaves the channel running.
  function automatic logic [1:0] f_power(logic [1:0] m, logic fn, logic pin);
    if (pin) begin
      return fn ? amct_pwr_standby : amct_pwr_full_down;
    end
    return (m == amct_pwr_reserved) ? amct_pwr_normal : m;
  endfunction

  genvar ch;
  for (ch = 0; ch < NCH; ch++) begin : g_ch
    amct_pat_if #(.W(W)) pif ();
    logic sel_wr;

    assign sel_wr = wr && chan_sel[ch];

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pwr_mode[ch] <= 2'(`AMCT_RST_PWR);
        pd_fn[ch] <= 1'(`AMCT_RST_PWR >> `AMCT_PWR_PDFN_BIT);
      end else if (sel_wr && addr == `AMCT_ADDR_PWR) begin
        pwr_mode[ch] <= wdata[1:0];
        pd_fn[ch] <= wdata[`AMCT_PWR_PDFN_BIT];
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        test_mode[ch] <= 4'(`AMCT_RST_TEST);
        single[ch] <= 1'(`AMCT_RST_TEST >> `AMCT_TEST_SINGLE_BIT);
        rst_long[ch] <= 1'(`AMCT_RST_TEST >> `AMCT_TEST_RST_LONG_BIT);
        rst_short[ch] <= 1'(`AMCT_RST_TEST >> `AMCT_TEST_RST_SHORT_BIT);
      end else if (sel_wr && addr == `AMCT_ADDR_TEST) begin
        test_mode[ch] <= wdata[3:0];
        single[ch] <= wdata[`AMCT_TEST_SINGLE_BIT];
        rst_long[ch] <= wdata[`AMCT_TEST_RST_LONG_BIT];
        rst_short[ch] <= wdata[`AMCT_TEST_RST_SHORT_BIT];
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        user_pat[ch] <= `AMCT_RST_UPAT;
      end else if (sel_wr && addr == `AMCT_ADDR_UPAT_LO) begin
        user_pat[ch][7:0] <= wdata;
      end else if (sel_wr && addr == `AMCT_ADDR_UPAT_HI) begin
        user_pat[ch][W-1:8] <= wdata[W-9:0];
      end
    end

    assign power_state[ch] = f_power(pwr_mode[ch], pd_fn[ch], pd_sync[1]);
    assign pif.tick = div_tick;
    assign pif.restart = sel_wr && addr == `AMCT_ADDR_TEST;
    assign pif.mode = test_mode[ch];
    assign pif.single = single[ch];
    assign pif.rst_long = rst_long[ch];
    assign pif.rst_short = rst_short[ch];
    assign pif.user_pat = user_pat[ch];
    assign pif.sample = sample[ch];
    assign out_data[ch] = pif.out_data;

    amct_pattern_gen #(.W(W)) u_gen (
      .clk(clk),
      .rstn(rstn),
      .pif(pif)
    );
  end

  // Reads return the lowest selected channel; open bits read as zero.
  assign rd_ch = !chan_sel[0];

  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      `AMCT_ADDR_CHAN: next_rdata = 8'(chan_sel);
      `AMCT_ADDR_PWR: begin
        next_rdata[1:0] = pwr_mode[rd_ch];
        next_rdata[`AMCT_PWR_PDFN_BIT] = pd_fn[rd_ch];
      end
      `AMCT_ADDR_GCLK: next_rdata[`AMCT_GCLK_CORR_BIT] = corrector_en;
      `AMCT_ADDR_DIV: next_rdata = {2'h0, div_phase, div_ratio};
      `AMCT_ADDR_TEST: begin
        next_rdata[3:0] = test_mode[rd_ch];
        next_rdata[`AMCT_TEST_SINGLE_BIT] = single[rd_ch];
        next_rdata[`AMCT_TEST_RST_LONG_BIT] = rst_long[rd_ch];
        next_rdata[`AMCT_TEST_RST_SHORT_BIT] = rst_short[rd_ch];
      end
      `AMCT_ADDR_UPAT_LO: next_rdata = user_pat[rd_ch][7:0];
      `AMCT_ADDR_UPAT_HI: next_rdata = 8'(user_pat[rd_ch][W-1:8]);
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Helper counters for the divider period check.
  logic [3:0] since_tick;
  logic [4:0] calm;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_tick <= 4'h0;
      calm <= 5'h00;
    end else begin
      since_tick <= div_tick ? 4'h1 : since_tick + 4'h1;
      if (wr && addr == `AMCT_ADDR_DIV) begin
        calm <= 5'h00;
      end else if (calm != 5'h1F) begin
        calm <= calm + 5'h01;
      end
    end
  end

  property p_div_period;
    @(posedge clk) disable iff (!rstn)
    div_tick && calm >= `AMCT_CALM_CYCLES
      |-> since_tick == {1'b0, div_ratio} + 4'h1;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("Divided clock period differs from the ratio.");

  property p_corrector_forced;
    @(posedge clk) disable iff (!rstn)
    div_ratio != 3'h0 |-> duty_cycle_corrector_on;
  endproperty
  a_corrector_forced: assert property (p_corrector_forced)
    else $error("Stabilizer not forced while dividing.");

  property p_pwr_code;
    @(posedge clk) disable iff (!rstn)
    !pd_sync[1] && pwr_mode[0] == amct_pwr_standby
      |-> power_state[0] == amct_pwr_standby;
  endproperty
  a_pwr_code: assert property (p_pwr_code)
    else $error("Internal power code not applied.");

  property p_pin_fn;
    @(posedge clk) disable iff (!rstn)
    $rose(pd_sync[1]) |-> power_state[0] ==
      (pd_fn[0] ? amct_pwr_standby : amct_pwr_full_down);
  endproperty
  a_pin_fn: assert property (p_pin_fn)
    else $error("Power-down pin function wrong.");

  property p_reset_defaults;
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> corrector_en && div_ratio == 3'h0 && div_phase == 3'h0 &&
      test_mode[0] == 4'h0 && pwr_mode[0] == 2'h0;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Register defaults wrong after reset.");
endmodule

// ### verification/amct_host_model.sv
`timescale 1ns/1ps
module amct_host_model (
  // Clock.
  input wire logic clk,
  // Register port toward the device.
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Strobes last one cycle and change only just after a rising edge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench import amct_pkg::*;;
  logic clk;
  logic rstn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic pdwn_pin;
  logic [1:0][11:0] sample;
  logic [1:0][11:0] out_data;
  logic out_valid;
  logic div_tick;
  logic duty_cycle_corrector_on;
  logic [1:0][1:0] power_state;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] rv;
  logic [11:0] prev;
  logic [11:0] upat;
  logic [1:0][11:0] s;
  int ticks;
  logic vt;
  int cyc = 0;
  int t0;
  int p;

  amct_regs #(.NCH(2), .W(12)) amct_regs_i (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pdwn_pin(pdwn_pin), .sample(sample), .out_data(out_data),
    .out_valid(out_valid), .div_tick(div_tick),
    .duty_cycle_corrector_on(duty_cycle_corrector_on),
    .power_state(power_state));

  amct_host_model amct_host_model_i (.clk(clk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  task automatic check(input string what, input logic [11:0] seen,
      input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    amct_host_model_i.write_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    amct_host_model_i.read_reg(a, rv);
    check($sformatf("reg %h", a), 12'(rv), 12'(e));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Test codes take effect on the tick after the write lands.
  task automatic tm(input logic [7:0] code);
    wr_reg(8'h0D, code);
    settle(3);
  endtask

  function automatic logic [11:0] fixed_pat(input logic [3:0] m);
    case (m)
      4'h1: return 12'h800;
      4'h2: return 12'hFFF;
      default: return 12'h000;
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free cycle count, used to measure where the divided pulse falls.
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    pdwn_pin = 1'b0;
    sample = '0;
    ticks = $urandom(32'h871F0C51);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h01);
    rd_chk(8'h0B, 8'h00);
    rd_chk(8'h0D, 8'h00);
    rd_chk(8'h30, 8'h00);
    check("corrector", 12'(duty_cycle_corrector_on), 12'h001);
    for (int c = 0; c < 3; c++) begin
      wr_reg(8'h08, 8'(c));
      settle(1);
      check("power a", 12'(power_state[0]), 12'(c));
      check("power b", 12'(power_state[1]), 12'(c));
      rd_chk(8'h08, 8'(c));
    end
    // The pin passes a two-flop synchroniser, so allow a few cycles.
    for (int f = 0; f < 2; f++) begin
      wr_reg(8'h08, 8'(f << 5));
      @(posedge clk);
      pdwn_pin <= 1'b1;
      settle(4);
      check("pin power", 12'(power_state[1]), f ? 12'h002 : 12'h001);
      @(posedge clk);
      pdwn_pin <= 1'b0;
      settle(4);
      check("pin off", 12'(power_state[0]), 12'h000);
    end
    // Only the selected channel takes a local power code.
    wr_reg(8'h05, 8'h01);
    wr_reg(8'h08, 8'h01);
    settle(1);
    check("local a", 12'(power_state[0]), 12'h001);
    check("local b", 12'(power_state[1]), 12'h000);
    wr_reg(8'h05, 8'h03);
    wr_reg(8'h09, 8'h00);
    settle(1);
    check("corrector off", 12'(duty_cycle_corrector_on), 12'h000);
    for (int d = 0; d < 7; d++) begin
      wr_reg(8'h0B, 8'(d | (($urandom % 8) << 3)));
      settle(20);
      check("forced", 12'(duty_cycle_corrector_on), 12'(d != 0));
      ticks = 0;
      vt = div_tick;
      for (int i = 0; i < 420; i++) begin
        settle(1);
        check("valid", 12'(out_valid), 12'(vt));
        vt = div_tick;
        ticks += int'(div_tick);
      end
      check("ticks", 12'(ticks), 12'(420 / (d + 1)));
    end
    // Same ratio keeps the counter running, so only the phase moves.
    wr_reg(8'h0B, 8'h06);
    settle(20);
    while (!div_tick) settle(1);
    t0 = cyc;
    p = $urandom % 8;
    wr_reg(8'h0B, 8'(6 | (p << 3)));
    settle(20);
    while (!div_tick) settle(1);
    check("phase", 12'((cyc - t0) % 7), 12'(p % 7));
    wr_reg(8'h0B, 8'h00);
    wr_reg(8'h09, 8'h01);
    for (int m = 1; m < 15; m++) begin
      if (m inside {[4:8]}) continue;
      tm(8'(m));
      check("fixed a", out_data[0], fixed_pat(4'(m)));
      check("fixed b", out_data[1], fixed_pat(4'(m)));
    end
    tm(8'h04);
    prev = out_data[0];
    settle(1);
    check("checker", out_data[0] ^ prev, 12'hFFF);
    check("checker v", 12'(prev == 12'hAAA || prev == 12'h555),
      12'h001);
    tm(8'h07);
    prev = out_data[1];
    settle(1);
    check("toggle", out_data[1] ^ prev, 12'hFFF);
    check("toggle v", 12'(prev == 12'hFFF || prev == 12'h000),
      12'h001);
    tm(8'h0F);
    prev = out_data[0];
    settle(1);
    check("ramp", out_data[0], prev + 12'h001);
    tm(8'h25);
    check("long held", out_data[0], 12'hFFF);
    tm(8'h16);
    check("short held", out_data[1], 12'h1FF);
    tm(8'h06);
    settle(64);
    check("short runs", 12'(out_data[1] != 12'h1FF), 12'h001);
    tm(8'h05);
    settle(64);
    check("long runs", 12'(out_data[0] != 12'hFFF), 12'h001);
    upat = 12'($urandom);
    wr_reg(8'h19, upat[7:0]);
    wr_reg(8'h1A, {4'h0, upat[11:8]});
    tm(8'h08);
    settle(2);
    check("user rep", out_data[0], upat);
    check("user rep b", out_data[1], upat);
    wr_reg(8'h0D, 8'h88);
    settle(1);
    check("user first", out_data[0], upat);
    settle(1);
    check("user once", out_data[0], 12'h000);
    tm(8'h00);
    for (int i = 0; i < 20; i++) begin
      s = {12'($urandom), 12'($urandom)};
      @(posedge clk);
      sample <= s;
      settle(1);
      check("pass a", out_data[0], s[0]);
      check("pass b", out_data[1], s[1]);
    end
    wr_reg(8'h08, 8'h02);
    wr_reg(8'h0D, 8'h02);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h0D, 8'h00);
    give_verdict();
  end
endmodule
